// >>> hw/sgc_pkg.sv
// Constants, field layout and carriers for the serializer pin configuration.
// Assumes an internal register port (address, write strobe, data) from the
// device's control interface and remote pin values from the control channel.
// What this block does
// R01 - Local output drives stored level bit
// R02 - Remote control on: drive received remote value
// R03 - Remote control off: ignore remote values
// R04 - Enable bit: 0 tri-state, 1 enabled; resets 1
// R05 - Pin 3 direction bit 5; 1 input while remote control is off
// R06 - Remote on for pins 0-2 after reset
// R07 - Pins 0/1 at 0x0D, 2/3 at 0x0E
// R08 - Reserved bits read zero, ignore writes
package sgc_pkg;

  localparam int SGC_ADDR_W = 8;
  localparam int SGC_DATA_W = 8;
  localparam int SGC_NPINS = 4;

  localparam logic [7:0] SGC_ADDR_PINS01 = 8'h0D;
  localparam logic [7:0] SGC_ADDR_PINS23 = 8'h0E;

  // Bit positions within each register; high pin uses 7/6/4, low uses 3/2/0
  localparam int SGC_HI_LEVEL = 7;
  localparam int SGC_HI_REMOTE = 6;
  localparam int SGC_DIR_BIT = 5;
  localparam int SGC_HI_DRIVE = 4;
  localparam int SGC_LO_LEVEL = 3;
  localparam int SGC_LO_REMOTE = 2;
  localparam int SGC_LO_DRIVE = 0;

  // Writable bit masks
  localparam logic [7:0] SGC_MASK_PINS01 = 8'hDD;
  localparam logic [7:0] SGC_MASK_PINS23 = 8'hFD;

  // Reset values
  localparam logic [7:0] SGC_RST_PINS01 = 8'h55;
  localparam logic [7:0] SGC_RST_PINS23 = 8'h35;

  // Register access carrier
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sgc_req_type;

  // Per-pin resolved control
  typedef struct packed {
    logic level;
    logic remote;
    logic drive_on;
    logic is_input;
  } sgc_pin_cfg_type;

endpackage : sgc_pkg

// >>> hw/sgc_pin_drv.sv
// One general-purpose pin: resolves drive, level and input sampling.
// Assumes the remote value is already in the clk domain.
`timescale 1ns/10ps
module sgc_pin_drv
  import sgc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration and remote value
  input sgc_pin_cfg_type cfg,
  input wire logic remote_val,
  // Pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic pin_in
);

  logic out_r;
  logic out_nxt;
  logic oe_r;
  logic oe_nxt;
  logic sync1_r;
  logic sync2_r;

  always_comb
  begin
    oe_nxt = 1'b0;
    out_nxt = 1'b0;
    if (cfg.drive_on) // [R04]
    begin
      if (cfg.remote) // [R02]
      begin
        oe_nxt = 1'b1;
        out_nxt = remote_val;
      end
      else if (!cfg.is_input) // [R01] [R03]
      begin
        oe_nxt = 1'b1;
        out_nxt = cfg.level;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  assign pin_o = out_r;
  assign pin_oe = oe_r;
  assign pin_in = sync2_r;

endmodule : sgc_pin_drv

// >>> hw/sgc_gpio_cfg.sv
// Top of the pin configuration block: two configuration registers and four
// pin drivers. Assumes a single-cycle register port on clk and remote
// pin values that arrive from the control channel asynchronously.
`timescale 1ns/10ps
module sgc_gpio_cfg
  import sgc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input sgc_req_type req,
  output logic [7:0] rdata,
  // Remote pin values from control channel
  input wire logic [3:0] remote_vals,
  // Pins
  input wire logic [3:0] pin_i,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe,
  output logic [3:0] pin_in
);

  logic [7:0] cfg01_r;
  logic [7:0] cfg01_nxt;
  logic [7:0] cfg23_r;
  logic [7:0] cfg23_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [3:0] rem_s1_r;
  logic [3:0] rem_s2_r;
  sgc_pin_cfg_type pin_cfg [SGC_NPINS];

  function automatic logic [7:0] wr_mask(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
    wr_mask = (old_v & ~mask) | (new_v & mask);
  endfunction : wr_mask

  always_comb
  begin
    cfg01_nxt = cfg01_r;
    cfg23_nxt = cfg23_r;
    if (req.wr && req.addr == SGC_ADDR_PINS01) // [R07]
      cfg01_nxt = wr_mask(cfg01_r, req.wdata, SGC_MASK_PINS01); // [R08]
    if (req.wr && req.addr == SGC_ADDR_PINS23) // [R07]
      cfg23_nxt = wr_mask(cfg23_r, req.wdata, SGC_MASK_PINS23); // [R08]
    case (req.addr)
      SGC_ADDR_PINS01: rdata_nxt = cfg01_r & SGC_MASK_PINS01; // [R08]
      SGC_ADDR_PINS23: rdata_nxt = cfg23_r & SGC_MASK_PINS23; // [R08]
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg01_r <= SGC_RST_PINS01; // [R04] [R06]
      cfg23_r <= SGC_RST_PINS23; // [R04] [R05] [R06]
      rdata_r <= 8'h00;
      rem_s1_r <= 4'h0;
      rem_s2_r <= 4'h0;
    end
    else
    begin
      cfg01_r <= cfg01_nxt;
      cfg23_r <= cfg23_nxt;
      rdata_r <= rdata_nxt;
      rem_s1_r <= remote_vals;
      rem_s2_r <= rem_s1_r;
    end
  end

  assign rdata = rdata_r;

  always_comb
  begin
    pin_cfg[0] = '{level: cfg01_r[SGC_LO_LEVEL],
                   remote: cfg01_r[SGC_LO_REMOTE],
                   drive_on: cfg01_r[SGC_LO_DRIVE], is_input: 1'b0};
    pin_cfg[1] = '{level: cfg01_r[SGC_HI_LEVEL],
                   remote: cfg01_r[SGC_HI_REMOTE],
                   drive_on: cfg01_r[SGC_HI_DRIVE], is_input: 1'b0};
    pin_cfg[2] = '{level: cfg23_r[SGC_LO_LEVEL],
                   remote: cfg23_r[SGC_LO_REMOTE],
                   drive_on: cfg23_r[SGC_LO_DRIVE], is_input: 1'b0};
    pin_cfg[3] = '{level: cfg23_r[SGC_HI_LEVEL],
                   remote: cfg23_r[SGC_HI_REMOTE],
                   drive_on: cfg23_r[SGC_HI_DRIVE],
                   is_input: cfg23_r[SGC_DIR_BIT]}; // [R05]
  end

  genvar gi;
  generate
    for (gi = 0; gi < SGC_NPINS; gi++)
    begin : g_pin
      sgc_pin_drv u_pin (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(pin_cfg[gi]),
        .remote_val(rem_s2_r[gi]),
        .pin_i(pin_i[gi]),
        .pin_o(pin_o[gi]),
        .pin_oe(pin_oe[gi]),
        .pin_in(pin_in[gi])
      );
    end
  endgenerate

endmodule : sgc_gpio_cfg

// >>> sim/sgc_gpio_cfg_checker.sv
// Assertions on the pin configuration block's ports.
// Bound to sgc_gpio_cfg; sees its ports only.
`timescale 1ns/10ps
module sgc_gpio_cfg_checker
  import sgc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Observed ports
  input sgc_req_type req,
  input wire logic [7:0] rdata,
  input wire logic [3:0] remote_vals,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe
);
  logic w0d;
  logic w0e;
  assign w0d = req.wr && req.addr == 8'h0D;
  assign w0e = req.wr && req.addr == 8'h0E;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rsv_zero_a: assert property (
    $past(req.addr) == 8'h0D |-> !rdata[5] && !rdata[1]) else $error("rsv");
  unmapped_a: assert property (
    !($past(req.addr) inside {8'h0D, 8'h0E}) |-> rdata == 8'h00)
    else $error("map");
  read_back_a: assert property (
    w0d ##1 !req.wr && req.addr == 8'h0D
    |=> rdata == ($past(req.wdata, 2) & 8'hDD)) else $error("rd");
  drive_off_a: assert property (
    w0d && !req.wdata[4] |-> ##2 !pin_oe[1]) else $error("off");
  local_lvl_a: assert property (
    w0d && req.wdata[2:0] == 3'b001
    |-> ##2 pin_oe[0] && pin_o[0] == $past(req.wdata[3], 2))
    else $error("lvl");
  remote_a: assert property (
    w0d && req.wdata[2:0] == 3'b101 ##1 (!req.wr && $stable(remote_vals))[*4]
    |-> pin_oe[0] && pin_o[0] == remote_vals[0]) else $error("remote");
  pin3_in_a: assert property (
    w0e && req.wdata[6:4] == 3'b011 |-> ##2 !pin_oe[3]) else $error("in");
  pin3_out_a: assert property (
    w0e && req.wdata[6:4] == 3'b001
    |-> ##2 pin_oe[3] && pin_o[3] == $past(req.wdata[7], 2))
    else $error("out");
endmodule : sgc_gpio_cfg_checker
bind sgc_gpio_cfg sgc_gpio_cfg_checker chk_u (.clk(clk), .rst_n(rst_n),
  .req(req), .rdata(rdata), .remote_vals(remote_vals), .pin_o(pin_o),
  .pin_oe(pin_oe));

// >>> sim/sgc_remote_model.sv
// Remote deserializer: presents pin values over the control channel.
// Values change 1 ns after the rising edge of clk.
`timescale 1ns/10ps
module sgc_remote_model
(
  // Clock, requested values and channel output
  input wire logic clk,
  input wire logic [3:0] want,
  output logic [3:0] remote_vals = 4'h0
);
  always @(posedge clk) remote_vals <= #1 want;
endmodule : sgc_remote_model

// >>> sim/sgc_gpio_cfg_tb.sv
// Bench for sgc_gpio_cfg: output-enable check after reset, register calls, then pin checks.
// Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
`define CHK(n, e, g) check_count++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %h got %h", n, e, g); err_total++; end
module sgc_gpio_cfg_tb
  import sgc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sgc_req_type req = '0;
  logic [7:0] rdata;
  logic [3:0] want = 4'h0;
  logic [3:0] rv, pin_o, pin_oe;
  logic [3:0] pin_i = 4'h0;
  logic [3:0] pin_in;
  int err_total = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  sgc_remote_model rm_u (.clk(clk), .want(want), .remote_vals(rv));
  sgc_gpio_cfg dut_u (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .remote_vals(rv), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_in(pin_in));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    req = '{1'b1, a, d};
    cyc(1);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cyc(1);
    req.addr = a;
    cyc(1);
    `CHK("rdata", e, rdata)
  endtask : rd
  task automatic wrap_up;
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial
  begin
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
    `CHK("oe", 4'h7, pin_oe)
    rd(8'h0D, 8'h55);
    rd(8'h0E, 8'h35);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, 8'h00);
    wr(8'h0D, 8'hFF);
    rd(8'h0D, 8'hDD);
    wr(8'h0E, 8'hFF);
    rd(8'h0E, 8'hFD);
    wr(8'h0D, 8'h09);
    cyc(4);
    `CHK("pin01", 3'b011, {pin_oe[1:0], pin_o[0]})
    want = 4'hA;
    wr(8'h0D, 8'h55);
    cyc(5);
    `CHK("pin01", 4'hE, {pin_oe[1:0], pin_o[1:0]})
    wr(8'h0D, 8'h11);
    cyc(2);
    `CHK("pin1", 2'b10, {pin_oe[1], pin_o[1]})
    wr(8'h0E, 8'h90);
    cyc(2);
    `CHK("pin23", 3'b101, {pin_oe[3:2], pin_o[3]})
    wr(8'h0E, 8'hB0);
    cyc(2);
    `CHK("pin3", 1'b0, pin_oe[3])
    pin_i = 4'h9;
    cyc(3);
    `CHK("pin_in", 4'h9, pin_in)
    wrap_up();
  end
endmodule : sgc_gpio_cfg_tb
